// >>> hw/ufc_flow_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Raise receive interrupt once receive fill reaches the trigger level.
// - Keep RTS asserted until fill reaches the upper hysteresis limit.
// - Reassert RTS once fill is drained to the lower hysteresis limit.
// - Keep storing received characters while RTS is deasserted, until full.
// - Automatic RTS starts only after RTS was asserted via modem control.
// - Fixed tables: limits are the next higher and next lower table levels.
// - Enhanced feature bit 7 enables automatic CTS flow control.
// - CTS drop sets source bit 5 when CTS interrupt is enabled.
// - On CTS drop finish current character then pause; resume on CTS.
// - Match received Xoff character(s); halt transmit after current character.
// - Xoff match with enable bit 5 sets flag and interrupt.
// - After Xoff, an Xon match resumes transmit and clears source bit 4.
// - Reset clears all Xon and Xoff character registers to zero.
// - Double mode compares two consecutive characters with Xon/Xoff pairs.
// - Consumed flow characters never reach the receive FIFO.
// - Send Xoff two character times after fill crosses the trigger.
// - Send Xon when fill falls to the lower hysteresis limit.
// - Enhanced bit 5 compares each character with Xoff2, still storing it.
// - Special character match sets source bit 4.
// - Comparisons use only the word length bits from line control.
// - Register bit 0 matches the received character's least significant bit.
// - Two partial sleep states: UART stopped, or charge pump stopped.
// - Enhanced feature bit 6 enables automatic RTS flow control.
module ufc_flow_ctrl
    import ufc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    // Receiver side
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic [LW-1:0] rx_level,
    output logic fifo_wr,
    output logic [7:0] fifo_wdata,
    // Transmitter side
    input wire logic char_tick,
    input wire logic tx_fc_ack,
    output logic tx_pause,
    output logic tx_fc_valid,
    output logic [7:0] tx_fc_data,
    // Modem pins
    input wire logic cts_n,
    output logic rts_n,
    // Power management
    input wire logic line_idle,
    input wire logic pump_autosleep_pin,
    output logic uart_sleep,
    output logic pump_off,
    // Interrupt
    output logic irq
);

    logic [7:0] enhanced_feature_reg;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] line_control_reg;
    logic [7:0] mcr;
    logic [7:0] xon1, xon2, xoff1, xoff2;
    logic [7:0] trig_cfg;
    logic [6:0] prog_level, prog_hyst;

    logic cts_s1, cts_s2, cts_d;
    logic pin_s1, pin_s2;
    logic rts_run, flag_fc, flag_modem, tx_halt, sent_xoff, above_d;
    logic held_valid, late_valid;
    logic [7:0] held_data, late_data;
    logic [1:0] tick_cnt;
    logic second_due;
    ufc_send_e state;

    logic [6:0] trig_level, upper, lower;
    logic [7:0] mask;
    logic [7:0] prog_sum;
    logic rx_en, pair, rx_int, int_pend, cts_drop, rts_rise, spc_hit;
    logic isr_rd;
    logic [7:0] on_c1, on_c2, off_c1, off_c2;
    logic on_full, on_part, on_brk, off_full, off_part, off_brk;
    logic any_full, any_part;
    logic [1:0] rx_mode, tx_mode, tab, sel;

    assign rx_mode = enhanced_feature_reg[FTR_RXM +: 2];
    assign tx_mode = enhanced_feature_reg[FTR_TXM +: 2];
    assign tab = trig_cfg[TRIG_TAB +: 2];
    assign sel = trig_cfg[TRIG_SEL +: 2];
    assign mask = ufc_mask(line_control_reg[1:0]);
    assign isr_rd = reg_rd && reg_addr == A_SRC;
    assign prog_sum = {1'b0, prog_level} + {1'b0, prog_hyst};

    // Hysteresis limits
    always_comb begin
        if (tab == TAB_PROG) begin
            trig_level = prog_level;
            upper = (prog_sum > {1'b0, FIFO_DEPTH}) ? FIFO_DEPTH : prog_sum[6:0];
            lower = (prog_level > prog_hyst) ? prog_level - prog_hyst : 7'h00;
        end else begin
            trig_level = TRIG_LEVELS[tab][sel];
            upper = (sel == 2'h3) ? FIFO_DEPTH : TRIG_LEVELS[tab][sel + 2'h1];
            lower = (sel == 2'h0) ? 7'h00 : TRIG_LEVELS[tab][sel - 2'h1];
        end
    end

    // Characters picked by mode; pair mode uses set 1 then set 2
    assign rx_en = rx_mode != FC_OFF;
    assign pair = rx_mode == FC_PAIR;
    assign on_c1 = (rx_mode == FC_SET2) ? xon2 : xon1;
    assign on_c2 = xon2;
    assign off_c1 = (rx_mode == FC_SET2) ? xoff2 : xoff1;
    assign off_c2 = xoff2;

    ufc_seq_match u_xon (
        .clk(clk),
        .sys_rst(sys_rst),
        .chr_valid(rx_valid && rx_en),
        .chr(rx_data),
        .mask(mask),
        .pair(pair),
        .c1(on_c1),
        .c2(on_c2),
        .full(on_full),
        .partial(on_part),
        .broken(on_brk)
    );

    ufc_seq_match u_xoff (
        .clk(clk),
        .sys_rst(sys_rst),
        .chr_valid(rx_valid && rx_en),
        .chr(rx_data),
        .mask(mask),
        .pair(pair),
        .c1(off_c1),
        .c2(off_c2),
        .full(off_full),
        .partial(off_part),
        .broken(off_brk)
    );

    assign any_full = on_full || off_full;
    assign any_part = on_part || off_part;
    assign spc_hit = rx_valid && enhanced_feature_reg[FTR_SPC]
        && ufc_eq(rx_data, xoff2, mask);
    assign rx_int = interrupt_enable_reg[IEN_RX] && rx_level >= trig_level;
    assign int_pend = rx_int || flag_fc || flag_modem;
    assign cts_drop = cts_s2 && !cts_d;
    assign rts_rise = rts_run && !rts_n && rts_upper_hit();

    function automatic logic rts_upper_hit();
        return rx_level >= upper;
    endfunction

    // Register writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            enhanced_feature_reg <= REG_RST;
            interrupt_enable_reg <= REG_RST;
            line_control_reg <= REG_RST;
            mcr <= REG_RST;
            xon1 <= REG_RST;
            xon2 <= REG_RST;
            xoff1 <= REG_RST;
            xoff2 <= REG_RST;
            trig_cfg <= REG_RST;
            prog_level <= DLVL_RST;
            prog_hyst <= HYST_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                A_FTR: enhanced_feature_reg <= reg_wdata;
                A_IEN: begin
                    // Upper enables are locked until the enhanced bit is set
                    interrupt_enable_reg[3:0] <= reg_wdata[3:0];
                    if (enhanced_feature_reg[FTR_ENH]) begin
                        interrupt_enable_reg[7:4] <= reg_wdata[7:4];
                    end
                end
                A_LNC: line_control_reg <= reg_wdata;
                A_MCR: mcr <= reg_wdata;
                A_XON1: xon1 <= reg_wdata;
                A_XON2: xon2 <= reg_wdata;
                A_XOFF1: xoff1 <= reg_wdata;
                A_XOFF2: xoff2 <= reg_wdata;
                A_TRIG: trig_cfg <= reg_wdata;
                A_DLVL: prog_level <= reg_wdata[6:0];
                A_HYST: prog_hyst <= reg_wdata[6:0];
                default: ;
            endcase
        end
    end

    // Register reads, data in the following cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                A_FTR: reg_rdata <= enhanced_feature_reg;
                A_IEN: reg_rdata <= interrupt_enable_reg;
                A_SRC: reg_rdata <= {2'h0, flag_modem, flag_fc, 1'h0, rx_int, 1'h0, !int_pend};
                A_LNC: reg_rdata <= line_control_reg;
                A_MCR: reg_rdata <= mcr;
                A_XON1: reg_rdata <= xon1;
                A_XON2: reg_rdata <= xon2;
                A_XOFF1: reg_rdata <= xoff1;
                A_XOFF2: reg_rdata <= xoff2;
                A_TRIG: reg_rdata <= trig_cfg;
                A_DLVL: reg_rdata <= {1'h0, prog_level};
                A_HYST: reg_rdata <= {1'h0, prog_hyst};
                A_STAT: reg_rdata <= {1'h0, pump_off, uart_sleep, sent_xoff, tx_halt,
                    rts_run, !rts_n, !cts_s2};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cts_s1 <= 1'b1;
            cts_s2 <= 1'b1;
            cts_d <= 1'b1;
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end else begin
            cts_s1 <= cts_n;
            cts_s2 <= cts_s1;
            cts_d <= cts_s2;
            pin_s1 <= pump_autosleep_pin;
            pin_s2 <= pin_s1;
        end
    end

    // Automatic RTS
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rts_run <= 1'b0;
            rts_n <= 1'b1;
        end else if (!enhanced_feature_reg[FTR_RTS] || !mcr[MCR_RTS]) begin
            rts_run <= 1'b0;
            rts_n <= !mcr[MCR_RTS];
        end else if (!rts_run) begin
            rts_run <= 1'b1;
            rts_n <= 1'b0;
        end else if (rx_level >= upper) begin
            rts_n <= 1'b1;
        end else if (rx_level <= lower) begin
            rts_n <= 1'b0;
        end
    end

    // Receive path; flow characters are withheld or dropped
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fifo_wr <= 1'b0;
            fifo_wdata <= 8'h00;
            held_valid <= 1'b0;
            held_data <= 8'h00;
            late_valid <= 1'b0;
            late_data <= 8'h00;
        end else begin
            fifo_wr <= 1'b0;
            if (late_valid) begin
                fifo_wr <= 1'b1;
                fifo_wdata <= late_data;
                late_valid <= 1'b0;
            end
            if (rx_valid) begin
                held_valid <= any_part;
                held_data <= rx_data;
                if (held_valid && !any_full) begin
                    // Broken pair: held first character goes in now, the second one late unless it starts a new pair
                    fifo_wr <= 1'b1;
                    fifo_wdata <= held_data;
                    if (!any_part) begin
                        late_valid <= 1'b1;
                        late_data <= rx_data;
                    end
                end else if (!any_full && !any_part) begin
                    fifo_wr <= 1'b1;
                    fifo_wdata <= rx_data;
                end
            end
        end
    end

    // Received Xoff / Xon and interrupt flags; set wins over clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_halt <= 1'b0;
            flag_fc <= 1'b0;
            flag_modem <= 1'b0;
        end else begin
            if (off_full) begin
                tx_halt <= 1'b1;
            end else if (on_full) begin
                tx_halt <= 1'b0;
            end
            if ((off_full && interrupt_enable_reg[IEN_XOFF]) || spc_hit) begin
                flag_fc <= 1'b1;
            end else if (on_full || isr_rd) begin
                flag_fc <= 1'b0;
            end
            if (cts_drop && interrupt_enable_reg[IEN_CTS]) begin
                flag_modem <= 1'b1;
            end else if (rts_rise && interrupt_enable_reg[IEN_RTS]) begin
                flag_modem <= 1'b1;
            end else if (isr_rd) begin
                flag_modem <= 1'b0;
            end
        end
    end

    // Transmitter only samples pause between characters
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_pause <= 1'b0;
        end else begin
            tx_pause <= (enhanced_feature_reg[FTR_CTS] && cts_s2) || tx_halt;
        end
    end

    // Outgoing Xoff / Xon sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= SND_IDLE;
            tick_cnt <= 2'h0;
            sent_xoff <= 1'b0;
            above_d <= 1'b0;
            second_due <= 1'b0;
            tx_fc_valid <= 1'b0;
            tx_fc_data <= 8'h00;
        end else begin
            above_d <= rx_level >= trig_level;
            unique case (state)
                SND_IDLE: begin
                    if (tx_mode == FC_OFF) begin
                        sent_xoff <= 1'b0;
                    end else if (!sent_xoff && rx_level >= trig_level && !above_d) begin
                        state <= SND_DELAY;
                        tick_cnt <= 2'h0;
                    end else if (sent_xoff && rx_level <= lower) begin
                        state <= SND_XON;
                        tx_fc_valid <= 1'b1;
                        tx_fc_data <= (tx_mode == FC_SET2) ? xon2 : xon1;
                        second_due <= tx_mode == FC_PAIR;
                    end
                end
                SND_DELAY: begin
                    if (char_tick) begin
                        tick_cnt <= tick_cnt + 2'h1;
                        if (tick_cnt == XOFF_DELAY_CHARS - 2'h1) begin
                            state <= SND_XOFF;
                            tx_fc_valid <= 1'b1;
                            tx_fc_data <= (tx_mode == FC_SET2) ? xoff2 : xoff1;
                            second_due <= tx_mode == FC_PAIR;
                        end
                    end
                end
                SND_XOFF, SND_XON: begin
                    if (tx_fc_ack) begin
                        if (second_due) begin
                            second_due <= 1'b0;
                            tx_fc_data <= (state == SND_XOFF) ? xoff2 : xon2;
                        end else begin
                            tx_fc_valid <= 1'b0;
                            sent_xoff <= state == SND_XOFF;
                            state <= SND_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Sleep states and interrupt output
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            uart_sleep <= 1'b0;
            pump_off <= 1'b0;
            irq <= 1'b0;
        end else begin
            uart_sleep <= interrupt_enable_reg[IEN_SLEEP] && !int_pend && line_idle;
            pump_off <= pin_s2 && line_idle;
            irq <= int_pend;
        end
    end

endmodule

// >>> hw/ufc_pkg.sv
package ufc_pkg;

    localparam int unsigned AW = 4;
    localparam int unsigned DW = 8;
    localparam int unsigned LW = 7;

    // Register offsets
    localparam logic [3:0] A_FTR = 4'h0;
    localparam logic [3:0] A_IEN = 4'h1;
    localparam logic [3:0] A_SRC = 4'h2;
    localparam logic [3:0] A_LNC = 4'h3;
    localparam logic [3:0] A_MCR = 4'h4;
    localparam logic [3:0] A_XON1 = 4'h5;
    localparam logic [3:0] A_XON2 = 4'h6;
    localparam logic [3:0] A_XOFF1 = 4'h7;
    localparam logic [3:0] A_XOFF2 = 4'h8;
    localparam logic [3:0] A_TRIG = 4'h9;
    localparam logic [3:0] A_DLVL = 4'hA;
    localparam logic [3:0] A_HYST = 4'hB;
    localparam logic [3:0] A_STAT = 4'hC;

    // Field positions
    localparam int unsigned FTR_CTS = 7;
    localparam int unsigned FTR_RTS = 6;
    localparam int unsigned FTR_SPC = 5;
    localparam int unsigned FTR_ENH = 4;
    localparam int unsigned FTR_TXM = 2;
    localparam int unsigned FTR_RXM = 0;
    localparam int unsigned IEN_RX = 0;
    localparam int unsigned IEN_SLEEP = 4;
    localparam int unsigned IEN_XOFF = 5;
    localparam int unsigned IEN_RTS = 6;
    localparam int unsigned IEN_CTS = 7;
    localparam int unsigned SRC_NONE = 0;
    localparam int unsigned SRC_RX = 2;
    localparam int unsigned SRC_FC = 4;
    localparam int unsigned SRC_MODEM = 5;
    localparam int unsigned MCR_RTS = 1;
    localparam int unsigned TRIG_SEL = 0;
    localparam int unsigned TRIG_TAB = 2;

    // Reset values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [6:0] DLVL_RST = 7'h20;
    localparam logic [6:0] HYST_RST = 7'h04;

    // Flow-character modes (both directions)
    localparam logic [1:0] FC_OFF = 2'h0;
    localparam logic [1:0] FC_SET1 = 2'h1;
    localparam logic [1:0] FC_SET2 = 2'h2;
    localparam logic [1:0] FC_PAIR = 2'h3;

    localparam logic [1:0] TAB_PROG = 2'h3;
    localparam logic [6:0] FIFO_DEPTH = 7'h40;
    localparam logic [1:0] XOFF_DELAY_CHARS = 2'h2;

    // Fixed trigger tables A, B, C; entry 0 lowest
    localparam logic [6:0] TRIG_LEVELS [3][4] = '{
        '{7'h08, 7'h10, 7'h38, 7'h3C},
        '{7'h08, 7'h10, 7'h18, 7'h1C},
        '{7'h08, 7'h10, 7'h20, 7'h38}
    };

    typedef enum logic [1:0] {SND_IDLE, SND_DELAY, SND_XOFF, SND_XON} ufc_send_e;

    function automatic logic [7:0] ufc_mask(input logic [1:0] wl);
        logic [7:0] m;
        m = 8'hFF;
        unique case (wl)
            2'h0: m = 8'h1F;
            2'h1: m = 8'h3F;
            2'h2: m = 8'h7F;
            2'h3: m = 8'hFF;
        endcase
        return m;
    endfunction

    function automatic logic ufc_eq(input logic [7:0] a, input logic [7:0] b,
                                    input logic [7:0] m);
        return ((a ^ b) & m) == 8'h00;
    endfunction

endpackage

// >>> hw/ufc_seq_match.sv
`timescale 1ns/1ps
module ufc_seq_match
    import ufc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Received character
    input wire logic chr_valid,
    input wire logic [7:0] chr,
    input wire logic [7:0] mask,
    // Pattern
    input wire logic pair,
    input wire logic [7:0] c1,
    input wire logic [7:0] c2,
    // Result, same cycle as chr_valid
    output logic full,
    output logic partial,
    output logic broken
);

    logic first_seen;

    always_comb begin
        full = 1'b0;
        partial = 1'b0;
        broken = 1'b0;
        if (chr_valid) begin
            if (!pair) begin
                full = ufc_eq(chr, c1, mask);
            end else if (first_seen) begin
                full = ufc_eq(chr, c2, mask);
                broken = !full;
            end else begin
                partial = ufc_eq(chr, c1, mask);
            end
        end
    end

    // A broken pair does not restart on the same character
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_seen <= 1'b0;
        end else if (chr_valid) begin
            first_seen <= partial;
        end
    end

endmodule

// >>> tb/ufc_flow_ctrl_assertions.sv
`timescale 1ns/1ps
module ufc_flow_ctrl_chk
    import ufc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Watched ports
    input wire logic reg_wr,
    input wire logic rx_valid,
    input wire logic [LW-1:0] rx_level,
    input wire logic fifo_wr,
    input wire logic tx_fc_ack,
    input wire logic tx_fc_valid,
    input wire logic [7:0] tx_fc_data,
    input wire logic tx_pause,
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic irq
);
    // Until software writes something, every feature except the pin-driven pump sleep is off
    logic wr_seen;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_seen <= 1'b0;
        end else if (reg_wr) begin
            wr_seen <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    rts_idle_a: assert property (!wr_seen |-> rts_n)
        else $error("rts asserted unconfigured");
    irq_idle_a: assert property (!wr_seen |-> !irq && !tx_pause)
        else $error("irq or pause unconfigured");
    fc_idle_a: assert property (!wr_seen |-> !tx_fc_valid)
        else $error("flow char unconfigured");
    fc_hold_a: assert property (tx_fc_valid && !tx_fc_ack |=> tx_fc_valid && $stable(tx_fc_data))
        else $error("flow char dropped early");
    fifo_cause_a: assert property (fifo_wr |-> $past(rx_valid) || $past(rx_valid, 2))
        else $error("fifo write without char");
    rts_move_a: assert property ($changed(rts_n) |->
        $past(reg_wr) || $past(reg_wr, 2) || $past(rx_level) != $past(rx_level, 3))
        else $error("rts moved without cause");
    pause_cause_a: assert property ($rose(tx_pause) |-> $past(rx_valid, 2) || $past(cts_n, 3)
        || $past(cts_n, 4) || $past(cts_n, 5) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("pause without cause");
    pause_release_a: assert property ($fell(tx_pause) |-> $past(rx_valid, 2) || !$past(cts_n, 3)
        || !$past(cts_n, 4) || !$past(cts_n, 5) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("resume without cause");
    cover property (tx_fc_valid && tx_fc_ack);
    cover property ($rose(rts_n));
    cover property ($rose(tx_pause));
endmodule

bind ufc_flow_ctrl ufc_flow_ctrl_chk chk_u (.clk, .sys_rst, .reg_wr, .rx_valid, .rx_level,
    .fifo_wr, .tx_fc_ack, .tx_fc_valid, .tx_fc_data, .tx_pause, .cts_n, .rts_n, .irq);

// >>> tb/ufc_flow_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks_done++; \
    if ((a) !== (b)) begin err_count++; $display("FAIL %0t %s", $time, m); end end
module ufc_flow_ctrl_tb
    import ufc_pkg::*;
;
    logic clk, sys_rst, reg_wr, reg_rd, rx_valid, char_tick, tx_fc_ack, fifo_wr, tx_pause;
    logic tx_fc_valid, cts_n, rts_n, line_idle, pump_autosleep_pin, uart_sleep, pump_off, irq;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata, reg_rdata;
    logic [7:0] rx_data, fifo_wdata, tx_fc_data, last_wr;
    logic [LW-1:0] rx_level;
    logic [3:0] ack_wait;
    int err_count, checks_done, wr_cnt;
    ufc_flow_ctrl dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .rx_valid, .rx_data, .rx_level, .fifo_wr, .fifo_wdata, .char_tick, .tx_fc_ack,
        .tx_pause, .tx_fc_valid, .tx_fc_data, .cts_n, .rts_n, .line_idle,
        .pump_autosleep_pin, .uart_sleep, .pump_off, .irq);
    ufc_remote rem_u (.clk, .sys_rst, .tx_fc_valid, .tx_fc_data, .ack_wait, .tx_fc_ack,
        .rx_valid, .rx_data, .cts_n);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (fifo_wr === 1'b1) begin
            wr_cnt++;
            last_wr = fifo_wdata;
        end
    end
    task automatic give_verdict;
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata & m, e, "read data")
    endtask
    task automatic lvl(input logic [LW-1:0] v);
        @(posedge clk);
        rx_level <= v;
        idle(3);
    endtask
    task automatic snd(input logic [7:0] c, input int w);
        int n;
        n = wr_cnt;
        rem_u.send_char(c);
        idle(3);
        `CHK(wr_cnt, n + w, "stored count")
    endtask
    task automatic tick;
        @(posedge clk);
        char_tick <= 1'b1;
        @(posedge clk);
        char_tick <= 1'b0;
    endtask
    task automatic wait_fc;
        int n;
        n = rem_u.fc_cnt;
        for (int i = 0; i < 40 && rem_u.fc_cnt == n; i++) @(posedge clk);
        #1;
        if (rem_u.fc_cnt == n) begin
            err_count++;
            give_verdict();
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        rx_level = 7'h00;
        char_tick = 1'b0;
        line_idle = 1'b0;
        pump_autosleep_pin = 1'b0;
        ack_wait = 4'h0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        wr(4'hE, 8'hFF);
        rd(4'hE, 8'hFF, 8'h00);
        for (int a = 5; a <= 8; a++) rd(a[3:0], 8'hFF, 8'h00);
        wr(A_XON1, 8'hA5);
        rd(A_XON1, 8'hFF, 8'hA5);
        // Auto RTS, table B, trigger 16
        wr(A_TRIG, 8'h05);
        wr(A_FTR, 8'h50);
        wr(A_IEN, 8'h01);
        idle(2);
        `CHK(rts_n, 1'b1, "rts early")
        wr(A_MCR, 8'h02);
        idle(2);
        `CHK(rts_n, 1'b0, "rts start")
        lvl(7'h10);
        `CHK(irq, 1'b1, "rx irq")
        rd(A_SRC, 8'h05, 8'h04);
        lvl(7'h17);
        `CHK(rts_n, 1'b0, "rts below upper")
        lvl(7'h18);
        `CHK(rts_n, 1'b1, "rts at upper")
        snd(8'h41, 1);
        lvl(7'h09);
        `CHK(rts_n, 1'b1, "rts above lower")
        lvl(7'h08);
        `CHK(rts_n, 1'b0, "rts at lower")
        // Auto CTS
        wr(A_FTR, 8'hD0);
        wr(A_IEN, 8'h80);
        rem_u.set_cts(1'b1);
        idle(6);
        `CHK(tx_pause, 1'b1, "cts pause")
        rd(A_SRC, 8'h20, 8'h20);
        rem_u.set_cts(1'b0);
        idle(6);
        `CHK(tx_pause, 1'b0, "cts resume")
        // Xon and Xoff on 7-bit words
        wr(A_LNC, 8'h02);
        wr(A_XOFF1, 8'h13);
        wr(A_XON1, 8'h11);
        wr(A_FTR, 8'h11);
        wr(A_IEN, 8'h20);
        snd(8'h93, 0);
        `CHK(tx_pause, 1'b1, "xoff halt")
        `CHK(irq, 1'b1, "xoff irq")
        rd(A_SRC, 8'h10, 8'h10);
        snd(8'h12, 1);
        snd(8'h11, 0);
        `CHK(tx_pause, 1'b0, "xon resume")
        rd(A_SRC, 8'h10, 8'h00);
        // Double-character mode
        wr(A_XOFF2, 8'h14);
        wr(A_XON2, 8'h12);
        wr(A_FTR, 8'h13);
        snd(8'h13, 0);
        snd(8'h14, 0);
        `CHK(tx_pause, 1'b1, "pair halt")
        snd(8'h11, 0);
        snd(8'h12, 0);
        `CHK(tx_pause, 1'b0, "pair resume")
        // Special character stays in the stream
        wr(A_FTR, 8'h30);
        snd(8'h94, 1);
        `CHK(last_wr, 8'h94, "special stored")
        rd(A_SRC, 8'h10, 8'h10);
        // Flow characters sent by the block, slow ack
        ack_wait <= 4'h5;
        wr(A_FTR, 8'h14);
        lvl(7'h10);
        tick();
        idle(4);
        `CHK(tx_fc_valid, 1'b0, "xoff too early")
        tick();
        wait_fc();
        `CHK(rem_u.last_fc, 8'h13, "xoff sent")
        lvl(7'h08);
        wait_fc();
        `CHK(rem_u.last_fc, 8'h11, "xon sent")
        // Partial sleep states
        wr(A_FTR, 8'h10);
        wr(A_IEN, 8'h10);
        line_idle <= 1'b1;
        pump_autosleep_pin <= 1'b1;
        idle(6);
        `CHK(uart_sleep, 1'b1, "uart sleep")
        `CHK(pump_off, 1'b1, "pump off")
        pump_autosleep_pin <= 1'b0;
        idle(6);
        `CHK(pump_off, 1'b0, "pump on")
        give_verdict();
    end
endmodule

// >>> tb/ufc_remote.sv
`timescale 1ns/1ps
module ufc_remote (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Flow characters from the block
    input wire logic tx_fc_valid,
    input wire logic [7:0] tx_fc_data,
    input wire logic [3:0] ack_wait,
    output logic tx_fc_ack,
    // Line towards the block
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic cts_n
);
    logic [3:0] wait_cnt;
    logic [7:0] last_fc;
    int fc_cnt;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        cts_n = 1'b0;
    end
    // A slow ack keeps the flow character standing for many cycles
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_fc_ack <= 1'b0;
            wait_cnt <= 4'h0;
            fc_cnt <= 0;
        end else if (tx_fc_ack) begin
            tx_fc_ack <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (tx_fc_valid) begin
            if (wait_cnt == ack_wait) begin
                tx_fc_ack <= 1'b1;
                last_fc <= tx_fc_data;
                fc_cnt <= fc_cnt + 1;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
    task automatic send_char(input logic [7:0] c);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data <= c;
        @(posedge clk);
        rx_valid <= 1'b0;
        // Idle data never repeats the last character
        rx_data <= ~c;
    endtask
    task automatic set_cts(input logic v);
        @(posedge clk);
        cts_n <= v;
    endtask
endmodule
